// ==== rtl/program_memory_table_read.v ====
// program memory with fetch and table-read path
//
// What this block does
// - code store of 16-bit words, 8K/16K
// - fetch by program counter, tables share store
// - fetch restarts at address zero after reset
// - table reads reach every code location
// - table address is high and low pointer
// - short ops sector 0, extended ops anywhere
// - low byte goes to named data location
// - high byte loads table high latch
// - table instruction takes two cycles
// - table high latch software readable and writable
// - serial programming data line, external clock
// - emulation variant keeps programming on debug pins
// - debug data bidirectional, debug clock input
// - bank select supplies top address bit on 16K variant only
//
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pmem_consts.vh"
module program_memory_table_read #(
  parameter LARGE = 1
) (
  input  wire                 I_CLK,
  input  wire                 I_ARST_N,
  input  wire                 I_PSEL,
  input  wire                 I_PENABLE,
  input  wire                 I_PWRITE,
  input  wire [11:0]          I_PADDR,
  input  wire [31:0]          I_PWDATA,
  output reg  [31:0]          O_PRDATA,
  output wire                 O_PREADY,
  output wire                 O_PSLVERR,
  input  wire [12:0]          I_FETCH_PC,
  output reg  [15:0]          O_INSTR,
  output reg                  O_FETCH_VALID,
  input  wire                 I_TBL_START,
  input  wire                 I_TBL_EXT,
  input  wire [15:0]          I_TBL_DEST,
  output reg                  O_TBL_BUSY,
  output reg                  O_TBL_DONE,
  output reg  [7:0]           O_DMEM_WDATA,
  output reg  [15:0]          O_DMEM_ADDR,
  output reg                  O_DMEM_WE,
  input  wire                 I_DEBUG_SERIAL_DATA,
  output wire                 O_DEBUG_SERIAL_DATA,
  output wire                 O_DEBUG_SERIAL_DATA_OE,
  input  wire                 I_DEBUG_SERIAL_CLOCK,
  output wire                 O_PIN_FUNC_EN
);
  localparam [1:0] ST_IDLE = `ST_IDLE;
  localparam [1:0] ST_READ = `ST_READ;
  localparam [1:0] ST_DONE = `ST_DONE;

  reg  [1:0]           state_reg;
  reg  [1:0]           state_next;
  reg  [7:0]           tblp_reg;
  reg  [7:0]           tbhp_reg;
  reg  [7:0]           table_high_latch_reg;
  reg                  code_bank_select_reg;
  reg  [1:0]           ctrl_reg;
  reg  [15:0]          pgm_data_reg;
  reg  [`CODE_AW-1:0]  pgm_addr_reg;
  reg                  pgm_we_reg;
  reg  [15:0]          dest_reg;
  reg                  fetch_pend_reg;
  reg                  sda_m_reg;
  reg                  sda_s_reg;
  reg                  sck_m_reg;
  reg                  sck_s_reg;
  reg                  sck_d_reg;
  reg  [15:0]          shift_reg;
  reg                  out_bit_reg;
  reg                  out_en_reg;
  reg                  after_reset_reg;
  wire [15:0]          rdata;
  wire [`CODE_AW-1:0]  mem_addr;
  wire [`CODE_AW-1:0]  tbl_addr;
  wire [`CODE_AW-1:0]  pc_addr;
  wire                 wr_acc;
  wire                 rd_acc;
  wire                 tbl_busy;
  wire                 sck_rise;

  // full code address, top bit from bank only on large variant
  function [`CODE_AW-1:0] full_addr;
    input [12:0] low;
    input        bank;
    begin
      full_addr = {(bank & (LARGE != 0)), low};
    end
  endfunction

  assign O_PREADY  = 1'b1;
  assign O_PSLVERR = 1'b0;
  assign wr_acc    = I_PSEL & I_PENABLE & I_PWRITE;
  assign rd_acc    = I_PSEL & ~I_PWRITE;
  assign tbl_busy  = (state_reg != ST_IDLE);

  assign tbl_addr = full_addr({tbhp_reg[4:0], tblp_reg}, code_bank_select_reg);
  assign pc_addr  = after_reset_reg ? `RESET_VECTOR : full_addr(I_FETCH_PC, code_bank_select_reg);
  assign mem_addr = pgm_we_reg ? pgm_addr_reg : (state_reg == ST_READ) ? tbl_addr : pc_addr;

  code_store u_store (
    .i_clk   (I_CLK),
    .i_addr  (mem_addr),
    .i_we    (pgm_we_reg),
    .i_wdata (pgm_data_reg),
    .o_rdata (rdata)
  );

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (I_TBL_START) begin
          state_next = ST_READ;
        end
      end
      ST_READ: state_next = ST_DONE;
      ST_DONE: state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  // two-flop synchronisers on the debug pins
  always @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      sda_m_reg <= 1'b0;
      sda_s_reg <= 1'b0;
      sck_m_reg <= 1'b0;
      sck_s_reg <= 1'b0;
      sck_d_reg <= 1'b0;
    end else begin
      sda_m_reg <= I_DEBUG_SERIAL_DATA;
      sda_s_reg <= sda_m_reg;
      sck_m_reg <= I_DEBUG_SERIAL_CLOCK;
      sck_s_reg <= sck_m_reg;
      sck_d_reg <= sck_s_reg;
    end
  end
  assign sck_rise = sck_s_reg & ~sck_d_reg;

  // serial shift, both directions on one line
  always @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      shift_reg   <= 16'h0000;
      out_bit_reg <= 1'b0;
      out_en_reg  <= 1'b0;
    end else begin
      // direction set by software, dropped when programming ends
      if (wr_acc && I_PADDR == `REG_PINS) begin
        out_en_reg <= I_PWDATA[`BIT_OUT_EN] & ctrl_reg[`BIT_PGM];
      end else if (!ctrl_reg[`BIT_PGM]) begin
        out_en_reg <= 1'b0;
      end
      if (ctrl_reg[`BIT_PGM] && sck_rise) begin
        shift_reg   <= {shift_reg[14:0], sda_s_reg};
        out_bit_reg <= pgm_data_reg[15];
      end
    end
  end
  assign O_DEBUG_SERIAL_DATA    = out_bit_reg;
  assign O_DEBUG_SERIAL_DATA_OE = out_en_reg & ctrl_reg[`BIT_PGM];
  // shared functions off on emulation variant
  assign O_PIN_FUNC_EN = ~ctrl_reg[`BIT_EV] & ~ctrl_reg[`BIT_PGM];

  always @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      state_reg            <= ST_IDLE;
      tblp_reg             <= 8'h00;
      tbhp_reg             <= 8'h00;
      table_high_latch_reg <= 8'h00;
      code_bank_select_reg <= 1'b0;
      ctrl_reg             <= 2'h0;
      pgm_data_reg         <= 16'h0000;
      pgm_addr_reg         <= 14'h0000;
      pgm_we_reg           <= 1'b0;
      dest_reg             <= 16'h0000;
      fetch_pend_reg       <= 1'b0;
      after_reset_reg      <= 1'b1;
      O_INSTR              <= 16'h0000;
      O_FETCH_VALID        <= 1'b0;
      O_TBL_BUSY           <= 1'b0;
      O_TBL_DONE           <= 1'b0;
      O_DMEM_WDATA         <= 8'h00;
      O_DMEM_ADDR          <= 16'h0000;
      O_DMEM_WE            <= 1'b0;
      O_PRDATA             <= 32'h0000_0000;
    end else begin
      state_reg       <= state_next;
      after_reset_reg <= 1'b0;
      pgm_we_reg      <= 1'b0;
      O_TBL_DONE      <= 1'b0;
      O_DMEM_WE       <= 1'b0;
      O_TBL_BUSY      <= (state_next != ST_IDLE);
      // store read has one cycle of latency
      fetch_pend_reg  <= ~tbl_busy & ~pgm_we_reg;
      O_FETCH_VALID   <= fetch_pend_reg;
      if (fetch_pend_reg) begin
        O_INSTR <= rdata;
      end
      if (state_reg == ST_IDLE && I_TBL_START) begin
        // short ops limited to sector 0
        dest_reg <= I_TBL_EXT ? I_TBL_DEST : {8'h00, I_TBL_DEST[7:0]};
      end
      if (state_reg == ST_DONE) begin
        O_DMEM_WDATA <= rdata[7:0];
        O_DMEM_ADDR  <= dest_reg;
        O_DMEM_WE    <= 1'b1;
        O_TBL_DONE   <= 1'b1;
      end
      if (wr_acc && I_PADDR == `REG_TBLP) begin
        tblp_reg <= I_PWDATA[7:0];
      end
      if (wr_acc && I_PADDR == `REG_TBHP) begin
        tbhp_reg <= I_PWDATA[7:0];
      end
      // held until replaced; table read wins
      if (state_reg == ST_DONE) begin
        table_high_latch_reg <= rdata[15:8];
      end else if (wr_acc && I_PADDR == `REG_TABLE_HIGH_LATCH) begin
        table_high_latch_reg <= I_PWDATA[7:0];
      end
      if (wr_acc && I_PADDR == `REG_BANK) begin
        code_bank_select_reg <= I_PWDATA[0];
      end
      if (wr_acc && I_PADDR == `REG_CTRL) begin
        ctrl_reg <= I_PWDATA[1:0];
      end
      if (wr_acc && I_PADDR == `REG_PGMD) begin
        pgm_data_reg <= I_PWDATA[15:0];
      end else if (ctrl_reg[`BIT_PGM] && sck_rise) begin
        pgm_data_reg <= {pgm_data_reg[14:0], sda_s_reg};
      end
      if (wr_acc && I_PADDR == `REG_PGMA) begin
        pgm_addr_reg <= I_PWDATA[`CODE_AW-1:0];
      end
      // writes only while programming enabled
      if (wr_acc && I_PADDR == `REG_PGWR && ctrl_reg[`BIT_PGM]) begin
        pgm_we_reg <= 1'b1;
      end
      if (rd_acc && !I_PENABLE) begin
        case (I_PADDR)
          `REG_CTRL: O_PRDATA <= {30'h0000_0000, ctrl_reg};
          `REG_TBLP: O_PRDATA <= {24'h00_0000, tblp_reg};
          `REG_TBHP: O_PRDATA <= {24'h00_0000, tbhp_reg};
          `REG_TABLE_HIGH_LATCH: O_PRDATA <= {24'h00_0000, table_high_latch_reg};
          `REG_BANK: O_PRDATA <= {31'h0000_0000, code_bank_select_reg};
          `REG_STAT: O_PRDATA <= {30'h0000_0000, O_TBL_BUSY, tbl_busy};
          `REG_PGMD: O_PRDATA <= {16'h0000, pgm_data_reg};
          `REG_PGMA: O_PRDATA <= {18'h0_0000, pgm_addr_reg};
          `REG_PINS: O_PRDATA <= {16'h0000, shift_reg};
          default:   O_PRDATA <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule // program_memory_table_read
`default_nettype wire

// ==== rtl/pmem_consts.vh ====
// constants for the program memory and table-read block
`ifndef PMEM_CONSTS_VH
`define PMEM_CONSTS_VH
`define CODE_AW          14
`define CODE_WORDS_SMALL 8192
`define CODE_WORDS_LARGE 16384
`define RESET_VECTOR     14'h0000
`define LOW_AW           13
`define RD_LAT_CYC       2'h1
`define DONE_CYC         2'h2
`define ST_IDLE          2'h0
`define ST_READ          2'h1
`define ST_DONE          2'h2
`define REG_CTRL         12'h000
`define REG_TBLP         12'h004
`define REG_TBHP         12'h008
`define REG_TABLE_HIGH_LATCH         12'h00c
`define REG_BANK         12'h010
`define REG_STAT         12'h014
`define REG_PGMD         12'h018
`define REG_PGMA         12'h01c
`define REG_PGWR         12'h020
`define REG_PINS         12'h024
`define BIT_EV           0
`define BIT_PGM          1
`define BIT_OUT_EN       0
`endif

// ==== rtl/code_store.v ====
// synchronous single-port 16-bit code store
`timescale 1ns/1ps
`default_nettype none
`include "pmem_consts.vh"
module code_store (
  input  wire                   i_clk,
  input  wire [`CODE_AW-1:0]    i_addr,
  input  wire                   i_we,
  input  wire [15:0]            i_wdata,
  output reg  [15:0]            o_rdata
);
  reg [15:0] mem [0:`CODE_WORDS_LARGE-1];
  always @(posedge i_clk) begin
    if (i_we) begin
      mem[i_addr] <= i_wdata;
    end
    o_rdata <= mem[i_addr];
  end
endmodule // code_store
`default_nettype wire

// ==== verif/pmtr_properties.sv ====
// checker for the table-read handshake of the program memory block
`timescale 1ns/1ps
`default_nettype none
module pmtr_props (
  input wire logic        I_CLK,
  input wire logic        I_ARST_N,
  input wire logic        I_TBL_START,
  input wire logic        I_TBL_EXT,
  input wire logic [15:0] I_TBL_DEST,
  input wire logic        O_TBL_BUSY,
  input wire logic        O_TBL_DONE,
  input wire logic        O_DMEM_WE,
  input wire logic [15:0] O_DMEM_ADDR,
  input wire logic [7:0]  O_DMEM_WDATA
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_ARST_N);
  property p_take; I_TBL_START && !O_TBL_BUSY |=> O_TBL_BUSY ##1 O_TBL_BUSY ##1 O_TBL_DONE && !O_TBL_BUSY; endproperty
  a_take: assert property (p_take) else $error("table read not done on third edge");
  property p_busy_len; $rose(O_TBL_BUSY) |-> O_TBL_BUSY[*2] ##1 !O_TBL_BUSY; endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy not two cycles");
  property p_done_cause; O_TBL_DONE |-> $past(O_TBL_BUSY, 2) && !$past(O_TBL_BUSY, 3); endproperty
  a_done_cause: assert property (p_done_cause) else $error("done without request");
  property p_done_pulse; O_TBL_DONE |=> !O_TBL_DONE; endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");
  property p_we_done; O_TBL_DONE |-> O_DMEM_WE; endproperty
  a_we_done: assert property (p_we_done) else $error("low byte not written at done");
  property p_short; O_DMEM_WE && !$past(I_TBL_EXT, 3) |-> O_DMEM_ADDR == ($past(I_TBL_DEST, 3) & 16'h00ff); endproperty
  a_short: assert property (p_short) else $error("short op left sector 0");
  property p_ext; O_DMEM_WE && $past(I_TBL_EXT, 3) |-> O_DMEM_ADDR == $past(I_TBL_DEST, 3); endproperty
  a_ext: assert property (p_ext) else $error("extended op wrong destination");
  property p_hold; !O_DMEM_WE |-> $stable(O_DMEM_WDATA); endproperty
  a_hold: assert property (p_hold) else $error("data byte moved without write");
endmodule // pmtr_props
bind program_memory_table_read pmtr_props chk_u (.I_CLK(I_CLK), .I_ARST_N(I_ARST_N), .I_TBL_START(I_TBL_START),
  .I_TBL_EXT(I_TBL_EXT), .I_TBL_DEST(I_TBL_DEST), .O_TBL_BUSY(O_TBL_BUSY), .O_TBL_DONE(O_TBL_DONE),
  .O_DMEM_WE(O_DMEM_WE), .O_DMEM_ADDR(O_DMEM_ADDR), .O_DMEM_WDATA(O_DMEM_WDATA));
`default_nettype wire

// ==== verif/cpu_model.sv ====
// core-side model: fetch address and table-read requests
`timescale 1ns/1ps
`default_nettype none
module cpu_model (
  input  wire logic        i_clk,
  input  wire logic        i_done,
  output var  logic [12:0] o_pc,
  output var  logic        o_start,
  output var  logic        o_ext,
  output var  logic [15:0] o_dest
);
  initial o_pc = 13'h1555;
  initial o_start = 1'b0;
  initial o_ext = 1'b0;
  initial o_dest = 16'h0000;
  task automatic fetch(input logic [12:0] a);
    @(posedge i_clk);
    o_pc <= a;
  endtask
  // dup keeps start up while busy, a request that must be ignored
  task automatic tbl(input logic ext, input logic [15:0] dest, input bit dup, output int dones);
    dones = 0;
    @(posedge i_clk);
    o_start <= 1'b1;
    o_ext <= ext;
    o_dest <= dest;
    for (int k = 0; k < 8; k++) begin
      @(posedge i_clk);
      if (i_done === 1'b1) dones++;
      o_start <= (k == 0) ? dup : 1'b0;
    end
  endtask
endmodule // cpu_model
`default_nettype wire

// ==== verif/program_memory_table_read_tb_top.sv ====
// self-checking bench for the program memory table-read block
`timescale 1ns/1ps
`default_nettype none
`include "pmem_consts.vh"
module program_memory_table_read_tb_top;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, q;
  logic        pready, fvalid, start, ext, busy, done, we, dbg_o, dbg_oe, pin_en, slverr;
  logic        sck = 1'b0;
  logic [12:0] pc;
  logic [15:0] instr, dest, daddr, d;
  logic [7:0]  wdata8;
  logic [13:0] ad[8];
  logic [15:0] wd[8];
  integer      seed;
  int          failures = 0;
  int          num_checks = 0;
  int          i, n;
  // released data line idles high through its pull-up
  wire dbg_line = dbg_oe ? dbg_o : 1'b1;
  always #10 clk = ~clk;
  program_memory_table_read #(.LARGE(1)) dut_u (.I_CLK(clk), .I_ARST_N(arst_n), .I_PSEL(psel),
    .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(slverr), .I_FETCH_PC(pc), .O_INSTR(instr), .O_FETCH_VALID(fvalid),
    .I_TBL_START(start), .I_TBL_EXT(ext), .I_TBL_DEST(dest), .O_TBL_BUSY(busy), .O_TBL_DONE(done),
    .O_DMEM_WDATA(wdata8), .O_DMEM_ADDR(daddr), .O_DMEM_WE(we), .I_DEBUG_SERIAL_DATA(dbg_line),
    .O_DEBUG_SERIAL_DATA(dbg_o), .O_DEBUG_SERIAL_DATA_OE(dbg_oe), .I_DEBUG_SERIAL_CLOCK(sck),
    .O_PIN_FUNC_EN(pin_en));
  cpu_model cpu_u (.i_clk(clk), .i_done(done), .o_pc(pc), .o_start(start), .o_ext(ext), .o_dest(dest));
  function automatic logic [15:0] xaddr(input logic e, input logic [15:0] a);
    return e ? a : {8'h00, a[7:0]};
  endfunction
  task automatic chk(input bit ok, input string m);
    num_checks++;
    if (!ok) begin
      failures++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wv, output logic [31:0] r);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wv;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic conclude;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    #1_000_000;
    failures++;
    conclude();
  end
  initial begin
    seed = 32'hc527_f622;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    apb(1'b1, 12'h0f0, 32'hffff_ffff, q);
    apb(1'b0, 12'h0f0, 32'h0000_0000, q);
    chk(q === 32'h0000_0000, "unmapped read not zero");
    chk(slverr === 1'b0 && pready === 1'b1, "bus error or stall");
    apb(1'b1, `REG_CTRL, 32'h0000_0002, q);
    // word 0 and the last word are corner cases, the rest random offsets with the index i as top three bits
    for (i = 0; i < 8; i++) begin
      ad[i] = (i == 0) ? 14'h0000 : (i == 7) ? 14'h3fff : {i[2:0], 11'($random(seed))};
      wd[i] = 16'($random(seed));
      apb(1'b1, `REG_PGMA, 32'(ad[i]), q);
      apb(1'b1, `REG_PGMD, 32'(wd[i]), q);
      apb(1'b1, `REG_PGWR, 32'h0000_0001, q);
    end
    apb(1'b1, `REG_CTRL, 32'h0000_0001, q);
    @(posedge clk);
    chk(pin_en === 1'b0, "pin functions on in emulation");
    apb(1'b1, `REG_CTRL, 32'h0000_0000, q);
    @(posedge clk);
    chk(pin_en === 1'b1, "pin functions off");
    for (i = 0; i < 8; i++) begin
      apb(1'b1, `REG_TBLP, 32'(ad[i][7:0]), q);
      apb(1'b1, `REG_TBHP, 32'(ad[i][12:8]), q);
      apb(1'b1, `REG_BANK, 32'(ad[i][13]), q);
      apb(1'b1, `REG_TABLE_HIGH_LATCH, 32'h0000_00a5, q);
      apb(1'b0, `REG_TABLE_HIGH_LATCH, 32'h0000_0000, q);
      chk(q[7:0] === 8'ha5, "latch write lost");
      d = 16'($random(seed));
      cpu_u.tbl(i[1], d, i[0], n);
      chk(n == 1, "done count");
      chk(wdata8 === wd[i][7:0], "low byte");
      chk(daddr === xaddr(i[1], d), "destination");
      apb(1'b0, `REG_TABLE_HIGH_LATCH, 32'h0000_0000, q);
      chk(q[7:0] === wd[i][15:8], "high byte");
      apb(1'b0, `REG_TBLP, 32'h0000_0000, q);
      chk(q[7:0] === ad[i][7:0], "pointer changed");
    end
    for (i = 1; i < 8; i++) begin
      apb(1'b1, `REG_BANK, 32'(ad[i][13]), q);
      cpu_u.fetch(ad[i][12:0]);
      repeat (4) @(posedge clk);
      chk(instr === wd[i] && fvalid === 1'b1, "fetch word");
    end
    // released line reads high through its pull-up
    apb(1'b1, `REG_CTRL, 32'h0000_0002, q);
    for (i = 0; i < 16; i++) begin
      sck <= 1'b1;
      repeat (3) @(posedge clk);
      sck <= 1'b0;
      repeat (3) @(posedge clk);
    end
    apb(1'b0, `REG_PINS, 32'h0000_0000, q);
    chk(q[15:0] === 16'hffff, "serial shift in");
    apb(1'b1, `REG_PINS, 32'h0000_0001, q);
    @(posedge clk);
    chk(dbg_oe === 1'b1 && dbg_o === 1'b1, "data pin not driven");
    apb(1'b1, `REG_CTRL, 32'h0000_0000, q);
    @(posedge clk);
    chk(dbg_oe === 1'b0, "pin driven outside programming");
    arst_n <= 1'b0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    for (n = 0; n < 10 && fvalid !== 1'b1; n++) @(posedge clk);
    chk(instr === wd[0], "first fetch not at zero");
    conclude();
  end
endmodule // program_memory_table_read_tb_top
`default_nettype wire
